// >>> core/rps_log.sv
// rps_log: circular store of the most recent operation records
// assumes writes come one cycle at a time from the stage on hclk
`timescale 1ns/1ps
`default_nettype none
module rps_log #(
    parameter int DEPTH = rps_pkg::LOG_DEPTH
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    rps_log_if.log lg
);
    typedef struct packed {
        logic [2:0] ev;
        logic [31:0] stamp;
        logic [31:0] p_now;
        logic [31:0] p_20;
        logic [31:0] p_200;
        logic [31:0] remain;
        logic [2:0] group;
    } rps_rec_t;

    typedef struct packed {
        logic [3:0] wptr;
        logic [3:0] fill;
        logic [31:0] rd_data;
    } rps_log_st_t;

    initial begin
        if (DEPTH < 1 || DEPTH > 15) $error("rps_log depth out of range");
    end

    rps_rec_t mem [DEPTH];
    rps_log_st_t st, next_st;
    rps_rec_t rr;
    logic [3:0] idx;

    // index 0 is newest; older entries step back around the ring
    always_comb begin
        next_st = st;
        // five bits: pointer plus depth overflows four
        idx = 4'((5'(st.wptr) + 5'(DEPTH) - 5'h1 - 5'(lg.rd_sel))
            % 5'(DEPTH));
        rr = mem[idx];
        case (lg.rd_word)
            3'h0: next_st.rd_data = {25'h0, rr.group, 1'b0, rr.ev};
            3'h1: next_st.rd_data = rr.stamp;
            3'h2: next_st.rd_data = rr.p_now;
            3'h3: next_st.rd_data = rr.p_20;
            3'h4: next_st.rd_data = rr.p_200;
            3'h5: next_st.rd_data = rr.remain;
            default: next_st.rd_data = 32'h0;
        endcase
        if (lg.rd_sel >= st.fill) next_st.rd_data = 32'h0;
        if (lg.wr) begin
            next_st.wptr = (st.wptr == 4'(DEPTH - 1)) ? 4'h0 : st.wptr + 4'h1;
            if (st.fill != 4'(DEPTH)) next_st.fill = st.fill + 4'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // oldest entry is overwritten once the ring is full
    always_ff @(posedge hclk) begin
        if (ce && lg.wr) begin
            mem[st.wptr] <= {lg.ev, lg.stamp, lg.p_now, lg.p_20, lg.p_200,
                lg.remain, lg.group};
        end
    end

    assign lg.rd_data = st.rd_data;
endmodule : rps_log
`default_nettype wire

// >>> core/rps_stage.sv
// rps_stage: reverse power protection stage with events, counters, log
// assumes power samples and block input come from the measurement
// chain and blocking matrix on their own timing; registers over ahb-lite
//
// Implementation choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - blocking is sampled at the start of each processing cycle before pick-up is evaluated.
// - pick-up without blocking raises start and starts the operate countdown.
// - pick-up while blocked raises blocked and nothing further is processed.
// - blocking during start drops start and runs the release timing as on pick-up loss.
// - trip and reset delays are definite time only.
// - start, trip and block emit on and off events, each selectable for the main buffer.
// - every event carries a 1 ms resolution timestamp.
// - resettable counters count start, trip and blocked events.
// - exactly one stage instance exists.
// - a twelve-entry circular log overwrites its oldest record.
// - records are written on on-transitions with time, event and now, -20 ms, -200 ms power.
// - records also hold remaining trip time up to 1800 s and the active setting group.
// - pick-up above threshold, release below 97 percent of it.
// - a status override to normal, start, trip or blocked acts only when forcing is enabled.
// - power inputs are taken on a 5 ms time base.
module rps_stage #(
    // cycles per ms tick; a bench may shorten it to keep runs brief
    parameter int TICK_CYC = rps_pkg::TICK_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [31:0] power_in,
    input wire logic block_in,
    output logic start_out,
    output logic trip_out,
    output logic blocked_out,
    output logic event_valid,
    output logic [2:0] event_code,
    output logic [31:0] event_stamp,
    output logic irq
);
    localparam int CYC_TICKS = rps_pkg::CYCLE_MS / rps_pkg::TICK_MS;

    // the ms divider is fifteen bits wide
    initial begin
        if (TICK_CYC < 1 || TICK_CYC > 32768)
            $error("tick length out of range");
    end

    typedef struct packed {
        logic [1:0] blk_sync;
        logic [14:0] div;
        logic [2:0] cyc;
        logic [31:0] stamp;
        logic [31:0] thresh;
        logic [31:0] opdly;
        logic [31:0] rsdly;
        logic [5:0] evsel;
        logic force_en;
        logic [1:0] force_st;
        logic [2:0] group;
        logic [5:0] irq_st;
        logic [5:0] irq_msk;
        logic [31:0] cnt_st;
        logic [31:0] cnt_tr;
        logic [31:0] cnt_bl;
        logic [3:0] log_sel;
        logic [31:0] timer;
        logic [31:0] rtimer;
        logic pickup;
        rps_pkg::rps_state_t state;
        logic [5:0] ev_pend;
        logic ap_valid;
        logic ap_write;
        logic [7:0] ap_addr;
        logic rd_pend;
        logic [31:0] hrdata;
        logic irq;
    } rps_st_t;

    rps_st_t st, next_st; // a single stage, no per-instance copies
    logic [31:0] hist [rps_pkg::HIST_DEPTH];
    logic [5:0] hptr;
    logic [5:0] next_hptr;
    logic tick_ms, tick_cyc, blk, pk, start_s, trip_s, blk_s;
    logic [2:0] ev_now;
    logic [31:0] wv;
    rps_pkg::rps_state_t nstate;
    rps_log_if lg();

    function automatic logic [5:0] hist_idx(input logic [5:0] p,
                                            input int back);
        int v;
        v = (int'(p) - back + 2 * rps_pkg::HIST_DEPTH) % rps_pkg::HIST_DEPTH;
        return 6'(v);
    endfunction : hist_idx

    function automatic logic [5:0] on_off(input logic was, input logic now,
                                          input int bitpos);
        logic [5:0] r;
        r = '0;
        r[bitpos] = now && !was;
        r[bitpos + 1] = was && !now;
        return r;
    endfunction : on_off

    rps_log #(.DEPTH(rps_pkg::LOG_DEPTH)) rps_log_i (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .lg(lg)
    );

    always_comb begin
        next_st = st;
        next_hptr = hptr;
        wv = hwdata;
        next_st.blk_sync = {st.blk_sync[0], block_in};
        tick_ms = (st.div == 15'(TICK_CYC - 1));
        next_st.div = tick_ms ? 15'h0 : st.div + 15'h1;
        if (tick_ms) next_st.stamp = st.stamp + 32'h1;
        tick_cyc = tick_ms && (st.cyc == 3'(CYC_TICKS - 1));
        if (tick_ms) next_st.cyc = tick_cyc ? 3'h0 : st.cyc + 3'h1;
        blk = st.blk_sync[1];
        pk = st.pickup;
        nstate = st.state;
        if (tick_cyc) begin
            // power taken only on the processing time base
            next_hptr = (hptr == 6'(rps_pkg::HIST_DEPTH - 1)) ? 6'h0
                : hptr + 6'h1;
            if (64'(power_in) * 64'd100 > 64'(st.thresh) * 64'd100)
                pk = 1'b1;
            else if (64'(power_in) * 64'd100 <
                     64'(st.thresh) * 64'(rps_pkg::HYST_PCT))
                pk = 1'b0;
            next_st.pickup = pk;
            // blocking read first, then pick-up decision
            case (st.state)
                rps_pkg::RPS_NORMAL: begin
                    if (pk && blk) nstate = rps_pkg::RPS_BLOCKED;
                    else if (pk) begin
                        nstate = rps_pkg::RPS_START;
                        next_st.timer = 32'h0;
                    end
                end
                rps_pkg::RPS_START: begin
                    if (!pk || blk) begin
                        nstate = rps_pkg::RPS_NORMAL;
                        next_st.rtimer = 32'h0;
                    end else if (st.timer + 32'(rps_pkg::CYCLE_MS) >= st.opdly)
                        nstate = rps_pkg::RPS_TRIP;
                    else next_st.timer = st.timer + 32'(rps_pkg::CYCLE_MS);
                end
                rps_pkg::RPS_TRIP: begin
                    // definite reset delay before trip drops
                    if (!pk || blk) begin
                        if (st.rtimer >= st.rsdly) nstate = rps_pkg::RPS_NORMAL;
                        else next_st.rtimer = st.rtimer
                            + 32'(rps_pkg::CYCLE_MS);
                    end else next_st.rtimer = 32'h0;
                end
                rps_pkg::RPS_BLOCKED: begin
                    if (!pk || !blk) nstate = rps_pkg::RPS_NORMAL;
                end
                default: nstate = rps_pkg::RPS_NORMAL;
            endcase
            if (st.force_en) nstate = rps_pkg::rps_state_t'(st.force_st);
            next_st.state = nstate;
        end
        start_s = st.state == rps_pkg::RPS_START || st.state == rps_pkg::RPS_TRIP;
        trip_s = st.state == rps_pkg::RPS_TRIP;
        blk_s = st.state == rps_pkg::RPS_BLOCKED;
        // on/off edges of each output, one per cycle in priority order
        next_st.ev_pend = st.ev_pend
            | on_off(start_out, start_s, 0) | on_off(trip_out, trip_s, 2)
            | on_off(blocked_out, blk_s, 4);
        ev_now = 3'h0;
        for (int i = 5; i >= 0; i--) begin
            if (st.ev_pend[i]) ev_now = 3'(i);
        end
        if (st.ev_pend != 6'h0) next_st.ev_pend[ev_now] = 1'b0;
        next_st.irq_st = st.irq_st | st.ev_pend;
        // count on emission: a bit queued behind a lower code stays set
        if (st.ev_pend != 6'h0 && ev_now == 3'h0)
            next_st.cnt_st = st.cnt_st + 32'h1;
        if (st.ev_pend != 6'h0 && ev_now == 3'h2)
            next_st.cnt_tr = st.cnt_tr + 32'h1;
        if (st.ev_pend != 6'h0 && ev_now == 3'h4)
            next_st.cnt_bl = st.cnt_bl + 32'h1;
        // bus: address phase captured, write done in data phase
        next_st.rd_pend = 1'b0;
        if (st.ap_valid && st.ap_write) begin
            case (st.ap_addr)
                rps_pkg::A_CTRL: begin
                    next_st.force_en = wv[rps_pkg::CTRL_FORCE_EN];
                    next_st.force_st = wv[rps_pkg::CTRL_FORCE_LSB +: 2];
                    next_st.group = wv[rps_pkg::CTRL_GROUP_LSB +: 3];
                    if (wv[rps_pkg::CTRL_CLR_CNT]) begin
                        next_st.cnt_st = 32'h0;
                        next_st.cnt_tr = 32'h0;
                        next_st.cnt_bl = 32'h0;
                    end
                end
                rps_pkg::A_THRESH: next_st.thresh = wv;
                rps_pkg::A_OPDLY: next_st.opdly = (wv > 32'(rps_pkg::MAX_DELAY_MS))
                    ? 32'(rps_pkg::MAX_DELAY_MS) : wv;
                rps_pkg::A_RSDLY: next_st.rsdly = wv;
                rps_pkg::A_EVSEL: next_st.evsel = wv[5:0];
                // set wins over write-one-to-clear
                rps_pkg::A_IRQST: next_st.irq_st = (st.irq_st & ~wv[5:0])
                    | st.ev_pend;
                rps_pkg::A_IRQMSK: next_st.irq_msk = wv[5:0];
                rps_pkg::A_LOGSEL: next_st.log_sel = wv[3:0];
                default: ;
            endcase
        end
        next_st.ap_valid = hsel && hready && htrans[1];
        next_st.ap_write = hwrite;
        next_st.ap_addr = haddr[7:0];
        // read data is taken in the address phase so it stands in the data
        // phase; next_st already holds a write landing at this same edge
        if (next_st.ap_valid && !hwrite) begin
            case (haddr[7:0])
                rps_pkg::A_CTRL: next_st.hrdata = {25'h0, next_st.group, 1'b0,
                    next_st.force_st, next_st.force_en};
                rps_pkg::A_THRESH: next_st.hrdata = next_st.thresh;
                rps_pkg::A_OPDLY: next_st.hrdata = next_st.opdly;
                rps_pkg::A_RSDLY: next_st.hrdata = next_st.rsdly;
                rps_pkg::A_EVSEL: next_st.hrdata = {26'h0, next_st.evsel};
                rps_pkg::A_STATUS: next_st.hrdata = {27'h0, st.pickup, blk,
                    blocked_out, trip_out, start_out};
                rps_pkg::A_IRQST: next_st.hrdata = {26'h0, next_st.irq_st};
                rps_pkg::A_IRQMSK: next_st.hrdata = {26'h0, next_st.irq_msk};
                rps_pkg::A_CNT_ST: next_st.hrdata = next_st.cnt_st;
                rps_pkg::A_CNT_TR: next_st.hrdata = next_st.cnt_tr;
                rps_pkg::A_CNT_BL: next_st.hrdata = next_st.cnt_bl;
                rps_pkg::A_LOGSEL: next_st.hrdata = {28'h0, next_st.log_sel};
                rps_pkg::A_TIME: next_st.hrdata = st.stamp;
                default: next_st.hrdata = 32'h0;
            endcase
            // log words need the log's registered read: one extra wait
            if (haddr[7:0] >= rps_pkg::A_LOGW0
                && haddr[7:0] <= rps_pkg::A_LOGW5)
                next_st.rd_pend = 1'b1;
        end
        if (st.rd_pend) next_st.hrdata = lg.rd_data;
        next_st.irq = |(next_st.irq_st & next_st.irq_msk);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
            st.thresh <= rps_pkg::THRESH_RST;
            st.opdly <= rps_pkg::OPDLY_RST;
            st.rsdly <= rps_pkg::RSDLY_RST;
            st.evsel <= rps_pkg::EVSEL_RST;
            hptr <= 6'h0;
            start_out <= 1'b0;
            trip_out <= 1'b0;
            blocked_out <= 1'b0;
            event_valid <= 1'b0;
            event_code <= 3'h0;
            event_stamp <= 32'h0;
            hreadyout <= 1'b1;
        end else if (ce) begin
            st <= next_st;
            hptr <= next_hptr;
            start_out <= start_s;
            trip_out <= trip_s;
            blocked_out <= blk_s;
            // only selected edges reach the main event buffer
            event_valid <= (st.ev_pend != 6'h0) && st.evsel[ev_now];
            event_code <= ev_now;
            event_stamp <= st.stamp;
            hreadyout <= !next_st.rd_pend;
        end
    end

    always_ff @(posedge hclk) begin
        if (ce && tick_cyc) hist[hptr] <= power_in;
    end

    // records only on on-transitions of start, trip, blocked
    assign lg.wr = ce && st.ev_pend != 6'h0 && !ev_now[0];
    assign lg.ev = ev_now;
    assign lg.stamp = st.stamp;
    assign lg.p_now = hist[hist_idx(hptr, 1)];
    assign lg.p_20 = hist[hist_idx(hptr, 1 + rps_pkg::PRE_TRIG_SLOTS)];
    assign lg.p_200 = hist[hist_idx(hptr, 1 + rps_pkg::PRE_FAULT_SLOTS)];
    assign lg.remain = (st.state == rps_pkg::RPS_START && st.opdly > st.timer)
        ? st.opdly - st.timer : 32'h0;
    assign lg.group = st.group;
    assign lg.rd_sel = next_st.log_sel;
    assign lg.rd_word = 3'((haddr[7:0] - rps_pkg::A_LOGW0) >> 2);
    assign hrdata = st.hrdata;
    assign hresp = 1'b0;
    assign irq = st.irq;
endmodule : rps_stage
`default_nettype wire

// >>> include/rps_log_if.sv
// rps_log_if: record write and read path between stage and fault log
// assumes both ends run on hclk
`timescale 1ns/1ps
`default_nettype none
interface rps_log_if;
    logic wr;
    logic [2:0] ev;
    logic [31:0] stamp;
    logic [31:0] p_now;
    logic [31:0] p_20;
    logic [31:0] p_200;
    logic [31:0] remain;
    logic [2:0] group;
    logic [3:0] rd_sel;
    logic [2:0] rd_word;
    logic [31:0] rd_data;
    modport stage (output wr, ev, stamp, p_now, p_20, p_200, remain, group,
        rd_sel, rd_word, input rd_data);
    modport log (input wr, ev, stamp, p_now, p_20, p_200, remain, group,
        rd_sel, rd_word, output rd_data);
endinterface : rps_log_if
`default_nettype wire

// >>> include/rps_pkg.sv
// rps_pkg: shared constants and types of the reverse power stage logic
// assumes a 20 MHz hclk and a 32-bit ahb-lite register bus
package rps_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int CYCLE_MS = 5;
    localparam int LOG_DEPTH = 12;
    // one slot beyond 200 ms so the oldest sample is not yet overwritten
    localparam int HIST_DEPTH = 41;
    localparam int PRE_TRIG_SLOTS = 4;
    localparam int PRE_FAULT_SLOTS = 40;
    localparam int HYST_PCT = 97;
    localparam int MAX_DELAY_MS = 1_800_000;

    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_THRESH = 8'h04;
    localparam logic [7:0] A_OPDLY = 8'h08;
    localparam logic [7:0] A_RSDLY = 8'h0c;
    localparam logic [7:0] A_EVSEL = 8'h10;
    localparam logic [7:0] A_STATUS = 8'h14;
    localparam logic [7:0] A_IRQST = 8'h18;
    localparam logic [7:0] A_IRQMSK = 8'h1c;
    localparam logic [7:0] A_CNT_ST = 8'h20;
    localparam logic [7:0] A_CNT_TR = 8'h24;
    localparam logic [7:0] A_CNT_BL = 8'h28;
    localparam logic [7:0] A_LOGSEL = 8'h2c;
    localparam logic [7:0] A_LOGW0 = 8'h30;
    localparam logic [7:0] A_LOGW5 = 8'h44;
    localparam logic [7:0] A_TIME = 8'h48;

    localparam int CTRL_FORCE_EN = 0;
    localparam int CTRL_FORCE_LSB = 1;
    localparam int CTRL_CLR_CNT = 3;
    localparam int CTRL_GROUP_LSB = 4;
    localparam logic [31:0] THRESH_RST = 32'h0000_2710;
    localparam logic [31:0] OPDLY_RST = 32'h0000_03e8;
    localparam logic [31:0] RSDLY_RST = 32'h0000_0000;
    localparam logic [5:0] EVSEL_RST = 6'h3f;

    typedef enum logic [1:0] {
        RPS_NORMAL = 2'h0, RPS_START = 2'h1, RPS_TRIP = 2'h3, RPS_BLOCKED = 2'h2
    } rps_state_t;

    typedef enum logic [2:0] {
        RPS_EV_START_ON = 3'h0, RPS_EV_START_OFF = 3'h1,
        RPS_EV_TRIP_ON = 3'h2, RPS_EV_TRIP_OFF = 3'h3,
        RPS_EV_BLOCK_ON = 3'h4, RPS_EV_BLOCK_OFF = 3'h5
    } rps_event_t;
endpackage : rps_pkg

// >>> tb/rps_far_end.sv
// rps_far_end: measurement chain, blocking matrix and event logger
// assumes hclk timing; the bench sets wanted power and block levels
`timescale 1ns/1ps
`default_nettype none
module rps_far_end (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [31:0] want_power,
    input wire logic want_block,
    input wire logic event_valid,
    input wire logic [2:0] event_code,
    output logic [31:0] power_in,
    output logic block_in,
    output logic [5:0] seen
);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            power_in <= 32'h0;
            block_in <= 1'b0;
            seen <= 6'h0;
        end else begin
            // power held as a level, far finer than the 5 ms base
            power_in <= want_power;
            // block follows at once, well ahead of any delay end
            block_in <= want_block;
            if (event_valid && event_code < 3'h6) begin
                seen[event_code] <= 1'b1;
            end
        end
    end
endmodule : rps_far_end
`default_nettype wire

// >>> tb/rps_stage_checker.sv
// rps_stage_checker: port assertions of the reverse power stage
// assumes one hclk domain, hresetn async active low
`timescale 1ns/1ps
`default_nettype none
module rps_stage_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic start_out,
    input wire logic trip_out,
    input wire logic blocked_out,
    input wire logic event_valid,
    input wire logic [2:0] event_code
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_trip_start;
        trip_out |-> start_out;
    endproperty
    a_trip_start: assert property (p_trip_start)
        else $error("trip without start");
    property p_excl;
        !(start_out && blocked_out);
    endproperty
    a_excl: assert property (p_excl)
        else $error("start and blocked together");
    property p_start_on;
        $rose(start_out) |-> ##[0:8]
            (event_valid && event_code == rps_pkg::RPS_EV_START_ON);
    endproperty
    a_start_on: assert property (p_start_on)
        else $error("no start on event");
    property p_start_off;
        $fell(start_out) |-> ##[0:8]
            (event_valid && event_code == rps_pkg::RPS_EV_START_OFF);
    endproperty
    a_start_off: assert property (p_start_off)
        else $error("no start off event");
    property p_trip_on;
        $rose(trip_out) |-> ##[0:8]
            (event_valid && event_code == rps_pkg::RPS_EV_TRIP_ON);
    endproperty
    a_trip_on: assert property (p_trip_on)
        else $error("no trip on event");
    property p_block_on;
        $rose(blocked_out) |-> ##[0:8]
            (event_valid && event_code == rps_pkg::RPS_EV_BLOCK_ON);
    endproperty
    a_block_on: assert property (p_block_on)
        else $error("no block on event");
    property p_ev_code;
        event_valid |-> event_code <= 3'h5;
    endproperty
    a_ev_code: assert property (p_ev_code)
        else $error("event code out of range");
    // wait states are only for log reads and last one cycle
    property p_ready;
        !hreadyout |=> hreadyout;
    endproperty
    a_ready: assert property (p_ready)
        else $error("wait state too long");
    property p_okay;
        hresp == 1'b0;
    endproperty
    a_okay: assert property (p_okay)
        else $error("response not okay");
    cover property ($rose(trip_out));
    cover property ($rose(blocked_out));
    cover property ($fell(start_out) && !trip_out);
endmodule : rps_stage_checker
bind rps_stage rps_stage_checker rps_stage_checker_i (.hclk(hclk),
    .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .start_out(start_out), .trip_out(trip_out), .blocked_out(blocked_out),
    .event_valid(event_valid), .event_code(event_code));
`default_nettype wire

// >>> tb/rps_stage_tb.sv
// rps_stage_tb: self-checking bench of the reverse power stage
// assumes a shortened tick of 20 cycles per ms, so 5 ms steps are 100
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_count++; \
    $display("[ERR] %0t got %h want %h", $time, (a), (e)); end end
module rps_stage_tb;
    localparam int TC = 20;
    localparam int PC = 5 * TC;
    localparam int LIMIT = 20000;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, want_power = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2, event_code;
    logic want_block = 1'b0, hreadyout, hresp, block_in, irq, event_valid;
    logic start_out, trip_out, blocked_out;
    logic [31:0] hrdata, power_in, event_stamp;
    logic [5:0] seen;
    int err_count = 0, n_tests = 0, cyc = 0;
    rps_stage #(.TICK_CYC(TC)) rps_stage_i (.hclk(hclk), .hresetn(hresetn),
        .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .power_in(power_in), .block_in(block_in), .start_out(start_out),
        .trip_out(trip_out), .blocked_out(blocked_out),
        .event_valid(event_valid), .event_code(event_code),
        .event_stamp(event_stamp), .irq(irq));
    rps_far_end rps_far_end_i (.hclk(hclk), .hresetn(hresetn),
        .want_power(want_power), .want_block(want_block),
        .event_valid(event_valid), .event_code(event_code),
        .power_in(power_in), .block_in(block_in), .seen(seen));
    initial begin
        forever #25 hclk = ~hclk;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize
    always @(posedge hclk) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_count++;
            summarize();
        end
    end
    task automatic ahb(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : ahb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        `CHK(r, e)
    endtask : rd
    // bounded wait: a stuck output costs at most four steps
    task automatic wait_for(input int s, input logic lvl);
        logic [2:0] v;
        int n;
        n = 0;
        v = {blocked_out, trip_out, start_out};
        while (v[s] !== lvl && n < 4 * PC) begin
            @(posedge hclk);
            v = {blocked_out, trip_out, start_out};
            n++;
        end
        `CHK(v[s], lvl)
    endtask : wait_for
    task automatic t_reset_values();
        rd(rps_pkg::A_THRESH, rps_pkg::THRESH_RST);
        rd(rps_pkg::A_OPDLY, rps_pkg::OPDLY_RST);
        rd(rps_pkg::A_RSDLY, rps_pkg::RSDLY_RST);
        rd(rps_pkg::A_EVSEL, {26'h0, rps_pkg::EVSEL_RST});
        rd(8'h80, 32'h0);
    endtask : t_reset_values
    task automatic t_time();
        logic [31:0] t0, t1;
        ahb(1'b0, rps_pkg::A_TIME, 32'h0, t0);
        repeat (2 * TC - 3) @(posedge hclk);
        ahb(1'b0, rps_pkg::A_TIME, 32'h0, t1);
        `CHK(t1 - t0, 32'h2)
    endtask : t_time
    task automatic t_start_block();
        wr(rps_pkg::A_THRESH, 32'h0000_03e8);
        wr(rps_pkg::A_IRQMSK, 32'h0000_003f);
        wr(rps_pkg::A_CTRL, 32'h0000_0030);
        want_power <= 32'h0000_07d0;
        wait_for(0, 1'b1);
        `CHK(trip_out, 1'b0)
        want_block <= 1'b1;
        wait_for(0, 1'b0);
        `CHK(trip_out, 1'b0)
        repeat (10) @(posedge hclk);
        `CHK(seen[1], 1'b1)
    endtask : t_start_block
    task automatic t_blocked();
        want_power <= 32'h0;
        repeat (2 * PC) @(posedge hclk);
        wr(rps_pkg::A_OPDLY, 32'h0000_0005);
        want_power <= 32'h0000_07d0;
        wait_for(2, 1'b1);
        `CHK(start_out, 1'b0)
        repeat (20) @(posedge hclk);
        `CHK(irq, 1'b1)
        wr(rps_pkg::A_IRQST, 32'h0000_003f);
        repeat (3) @(posedge hclk);
        `CHK(irq, 1'b0)
    endtask : t_blocked
    task automatic t_trip();
        want_block <= 1'b0;
        wait_for(1, 1'b1);
        `CHK(start_out, 1'b1)
        repeat (20) @(posedge hclk);
        rd(rps_pkg::A_CNT_ST, 32'h2);
        rd(rps_pkg::A_CNT_TR, 32'h1);
        wr(rps_pkg::A_LOGSEL, 32'h0);
        rd(rps_pkg::A_LOGW0, 32'h0000_0032);
        rd(8'h38, 32'h0000_07d0);
        rd(rps_pkg::A_LOGW5, 32'h0);
        wr(rps_pkg::A_CTRL, 32'h0000_0038);
        rd(rps_pkg::A_CNT_ST, 32'h0);
        rd(rps_pkg::A_CNT_TR, 32'h0);
    endtask : t_trip
    task automatic t_force();
        wr(rps_pkg::A_CTRL, 32'h0000_0035);
        wait_for(2, 1'b1);
        `CHK(trip_out, 1'b0)
    endtask : t_force
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset_values();
        t_time();
        t_start_block();
        t_blocked();
        t_trip();
        t_force();
        summarize();
    end
endmodule : rps_stage_tb
`default_nettype wire
